// ==== nipl_pkg.sv ====
package nipl_pkg;

  // vector map
  localparam int NUM_VEC = 14;
  localparam int TLI_VEC = 0;
  localparam logic [15:0] VEC_ADDR_TOP = 16'hFFFA;
  localparam logic [13:0] HALT_WAKE_MASK = 14'h00D9;

  // register byte offsets
  localparam logic [7:0] OFF_CC = 8'h00;
  localparam logic [7:0] OFF_VECTOR_PRIORITY_0 = 8'h04;
  localparam logic [7:0] OFF_VECTOR_PRIORITY_1 = 8'h08;
  localparam logic [7:0] OFF_VECTOR_PRIORITY_2 = 8'h0C;
  localparam logic [7:0] OFF_VECTOR_PRIORITY_3 = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // field positions and reset values
  localparam int CC_PRIO_HI_POS = 5;
  localparam int CC_PRIO_LO_POS = 3;
  localparam int STATUS_MODE_POS = 16;
  localparam logic [7:0] CC_RESET = 8'hEA;
  localparam logic [7:0] CC_FIXED_ONES = 8'hC0;
  localparam logic [7:0] ISPR_RESET = 8'hFF;
  localparam logic [3:0] VECTOR_PRIORITY_3_RO_ONES = 4'hF;
  localparam logic [13:0] IRQ_EN_RESET = 14'h0000;

  // priority encodings
  localparam logic [1:0] PRIO_LEVEL0 = 2'b10;
  localparam logic [1:0] PRIO_LEVEL1 = 2'b01;
  localparam logic [1:0] PRIO_LEVEL2 = 2'b00;
  localparam logic [1:0] PRIO_LEVEL3 = 2'b11;

  // oscillator stabilisation after halt, in cpu clock cycles
  localparam int STAB_CYCLES = 512;

  typedef enum logic [2:0] {
    OP_RIM = 3'b000,
    OP_SIM = 3'b001,
    OP_HALT = 3'b010,
    OP_WFI = 3'b011,
    OP_POPCC = 3'b100,
    OP_RETURN_FROM_IRQ_INSTR = 3'b101,
    OP_TRAP = 3'b110
  } nipl_op_type;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_HALT = 2'b10,
    MODE_STAB = 2'b11
  } nipl_mode_type;

  // encoding to rank, 0 = main level, 3 = disabled/highest
  function automatic logic [1:0] prio_rank(input logic [1:0] enc);
    case (enc)
      PRIO_LEVEL0: prio_rank = 2'd0;
      PRIO_LEVEL1: prio_rank = 2'd1;
      PRIO_LEVEL2: prio_rank = 2'd2;
      default: prio_rank = 2'd3;
    endcase
  endfunction

  function automatic logic [7:0] cc_set_prio(input logic [7:0] cc, input logic [1:0] enc);
    logic [7:0] r;
    r = cc;
    r[CC_PRIO_HI_POS] = enc[1];
    r[CC_PRIO_LO_POS] = enc[0];
    cc_set_prio = r;
  endfunction

endpackage

// ==== nipl_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none

module nipl_arbiter #(
  parameter int NUM = 14,
  parameter int VW = 4
) (
  // eligible requests and their ranks
  input wire logic [NUM-1:0] request,
  input wire logic [2*NUM-1:0] rank,
  // winner
  output logic found,
  output logic [VW-1:0] vector
);

  logic [1:0] best;

  // strictly greater keeps the lower vector number on a tie
  always_comb begin
    found = 1'b0;
    vector = '0;
    best = 2'd0;
    for (int i = 0; i < NUM; i++) begin
      if (request[i] && (!found || rank[2*i +: 2] > best)) begin
        found = 1'b1;
        best = rank[2*i +: 2];
        vector = VW'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ==== nipl_controller.sv ====
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module nipl_controller #(
  parameter int STAB_COUNT = nipl_pkg::STAB_CYCLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic cpu_op_valid,
  input wire nipl_pkg::nipl_op_type cpu_op,
  input wire logic [7:0] cpu_cc_in,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [3:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic [7:0] condition_code_reg,
  // interrupt sources
  input wire logic [nipl_pkg::NUM_VEC-1:0] irq_lines,
  // power control
  output logic cpu_run,
  output logic periph_run,
  output logic osc_enable
);

  import nipl_pkg::*;

  localparam int CW = $clog2(STAB_COUNT + 1);
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_COUNT - 1);

  logic [7:0] cc;
  logic [7:0] next_cc;
  logic [2*NUM_VEC-1:0] field_prio;
  logic [2*NUM_VEC-1:0] next_field_prio;
  logic [NUM_VEC-1:0] pending;
  logic [NUM_VEC-1:0] next_pending;
  logic [NUM_VEC-1:0] irq_en;
  nipl_mode_type mode;
  nipl_mode_type next_mode;
  logic [CW-1:0] stab_cnt;
  logic halt_first;
  logic next_halt_first;
  logic [2*NUM_VEC-1:0] rank_vec;
  logic [NUM_VEC-1:0] eligible;
  logic arb_found;
  logic [3:0] arb_vec;
  logic [31:0] read_value;
  logic [NUM_VEC-1:0] ack_clear;

  // merge a written byte into four fields, refusing the level0 pattern
  function automatic logic [7:0] ispr_merge(input logic [7:0] old_val, input logic [7:0] wr);
    logic [7:0] r;
    r = old_val;
    for (int f = 0; f < 4; f++) begin
      if (wr[2*f +: 2] != PRIO_LEVEL0) begin
        r[2*f +: 2] = wr[2*f +: 2];
      end
    end
    ispr_merge = r;
  endfunction

  // vector addresses descend two bytes per field
  function automatic logic [15:0] vec_addr(input logic [3:0] v);
    vec_addr = VEC_ADDR_TOP - {11'h000, v, 1'b0};
  endfunction

  // apb decode
  wire apb_setup = psel & ~penable & clk_en;
  wire apb_access = psel & penable & clk_en;
  wire apb_wr = apb_access & pwrite;
  wire sel_cc = paddr == OFF_CC;
  wire sel_vector_priority_0 = paddr == OFF_VECTOR_PRIORITY_0;
  wire sel_vector_priority_1 = paddr == OFF_VECTOR_PRIORITY_1;
  wire sel_vector_priority_2 = paddr == OFF_VECTOR_PRIORITY_2;
  wire sel_vector_priority_3 = paddr == OFF_VECTOR_PRIORITY_3;
  wire sel_irq_en = paddr == OFF_IRQ_EN;
  wire sel_status = paddr == OFF_STATUS;
  wire addr_ok = sel_cc | sel_vector_priority_0 | sel_vector_priority_1 | sel_vector_priority_2 | sel_vector_priority_3 | sel_irq_en |
    sel_status;
  wire sel_ro = sel_status;
  wire wr_ok = apb_wr & addr_ok & ~sel_ro;
  wire [7:0] vector_priority_3_merged = ispr_merge({VECTOR_PRIORITY_3_RO_ONES, field_prio[27:24]}, pwdata[7:0]);

  assign pready = clk_en;
  assign pslverr = psel & penable & ~addr_ok;

  // core side decode
  wire take = irq_ack & irq_req;
  wire op_go = cpu_op_valid & (mode == MODE_RUN);
  wire [1:0] cur_enc = {cc[CC_PRIO_HI_POS], cc[CC_PRIO_LO_POS]};
  wire [1:0] cur_rank = prio_rank(cur_enc);
  wire [1:0] taken_field = field_prio[2*irq_vector +: 2];
  wire in_halt = (mode == MODE_HALT) | (mode == MODE_STAB);
  wire halt_gate = in_halt | halt_first;
  wire [NUM_VEC-1:0] wake_mask = halt_gate ? HALT_WAKE_MASK : {NUM_VEC{1'b1}};
  wire stab_done = (mode == MODE_STAB) && (stab_cnt == STAB_LAST);

  // eligibility and rank of each pending vector
  always_comb begin
    rank_vec = '0;
    eligible = '0;
    for (int i = 0; i < NUM_VEC; i++) begin
      if (i == TLI_VEC) begin
        // top-level source ignores its field and any mask
        rank_vec[2*i +: 2] = 2'd3;
        eligible[i] = pending[i] & wake_mask[i];
      end else begin
        rank_vec[2*i +: 2] = prio_rank(field_prio[2*i +: 2]);
        eligible[i] = pending[i] & irq_en[i] & wake_mask[i] &
          (prio_rank(field_prio[2*i +: 2]) > cur_rank);
      end
    end
  end

  nipl_arbiter #(
    .NUM(NUM_VEC),
    .VW(4)
  ) u_arbiter (
    .request(eligible),
    .rank(rank_vec),
    .found(arb_found),
    .vector(arb_vec)
  );

  // condition code next value
  always_comb begin
    next_cc = cc;
    if (take) begin
      if (irq_vector == 4'(TLI_VEC)) begin
        next_cc = cc_set_prio(cc, PRIO_LEVEL3);
      end else begin
        next_cc = cc_set_prio(cc, taken_field);
      end
    end else if (op_go) begin
      case (cpu_op)
        OP_RIM: next_cc = cc_set_prio(cc, PRIO_LEVEL0);
        OP_SIM: next_cc = cc_set_prio(cc, PRIO_LEVEL3);
        OP_HALT: next_cc = cc_set_prio(cc, PRIO_LEVEL0);
        OP_WFI: next_cc = cc_set_prio(cc, PRIO_LEVEL0);
        OP_POPCC: next_cc = cpu_cc_in;
        OP_RETURN_FROM_IRQ_INSTR: next_cc = cpu_cc_in;
        OP_TRAP: next_cc = cc_set_prio(cc, PRIO_LEVEL3);
        default: next_cc = cc;
      endcase
    end else if (wr_ok && sel_cc) begin
      next_cc = pwdata[7:0];
    end
    next_cc = next_cc | CC_FIXED_ONES;
  end

  // priority fields next value
  always_comb begin
    next_field_prio = field_prio;
    if (wr_ok && sel_vector_priority_0) begin
      next_field_prio[7:0] = ispr_merge(field_prio[7:0], pwdata[7:0]);
    end
    if (wr_ok && sel_vector_priority_1) begin
      next_field_prio[15:8] = ispr_merge(field_prio[15:8], pwdata[7:0]);
    end
    if (wr_ok && sel_vector_priority_2) begin
      next_field_prio[23:16] = ispr_merge(field_prio[23:16], pwdata[7:0]);
    end
    if (wr_ok && sel_vector_priority_3) begin
      next_field_prio[27:24] = vector_priority_3_merged[3:0];
    end
  end

  // pending latches; a new request wins over the service clear
  always_comb begin
    ack_clear = '0;
    if (take) begin
      ack_clear[irq_vector] = 1'b1;
    end
    next_pending = (pending & ~ack_clear) | irq_lines;
  end

  // power mode sequencing
  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_RUN: begin
        if (op_go && cpu_op == OP_WFI) begin
          next_mode = MODE_WAIT;
        end else if (op_go && cpu_op == OP_HALT) begin
          next_mode = MODE_HALT;
        end
      end
      MODE_WAIT: begin
        if (arb_found) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_HALT: begin
        if (arb_found) begin
          next_mode = MODE_STAB;
        end
      end
      MODE_STAB: begin
        if (stab_done) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  // first service after halt must be a wake-capable source
  always_comb begin
    next_halt_first = halt_first;
    if (stab_done) begin
      next_halt_first = 1'b1;
    end else if (take) begin
      next_halt_first = 1'b0;
    end
  end

  // request stays low one cycle after a take or op so stale state never wins
  wire next_irq_req = (mode == MODE_RUN) & arb_found & ~take & ~op_go;

  // register read mux
  always_comb begin
    read_value = 32'h0000_0000;
    case (1'b1)
      sel_cc: read_value[7:0] = cc;
      sel_vector_priority_0: read_value[7:0] = field_prio[7:0];
      sel_vector_priority_1: read_value[7:0] = field_prio[15:8];
      sel_vector_priority_2: read_value[7:0] = field_prio[23:16];
      sel_vector_priority_3: read_value[7:0] = {VECTOR_PRIORITY_3_RO_ONES, field_prio[27:24]};
      sel_irq_en: read_value[NUM_VEC-1:0] = irq_en;
      sel_status: begin
        read_value[NUM_VEC-1:0] = pending;
        read_value[STATUS_MODE_POS +: 2] = mode;
      end
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc <= CC_RESET;
      field_prio <= {ISPR_RESET[3:0], ISPR_RESET, ISPR_RESET, ISPR_RESET};
      pending <= '0;
      mode <= MODE_RUN;
      halt_first <= 1'b0;
    end else if (clk_en) begin
      cc <= next_cc;
      field_prio <= next_field_prio;
      pending <= next_pending;
      mode <= next_mode;
      halt_first <= next_halt_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= IRQ_EN_RESET;
    end else if (clk_en && wr_ok && sel_irq_en) begin
      irq_en <= pwdata[NUM_VEC-1:0];
    end
  end

  // stabilisation counter runs only while waiting for the oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt <= '0;
    end else if (clk_en) begin
      if (mode == MODE_STAB && !stab_done) begin
        stab_cnt <= stab_cnt + CW'(1);
      end else begin
        stab_cnt <= '0;
      end
    end
  end

  // service request to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= 4'h0;
      irq_vector_addr <= VEC_ADDR_TOP;
    end else if (clk_en) begin
      irq_req <= next_irq_req;
      irq_vector <= arb_vec;
      irq_vector_addr <= vec_addr(arb_vec);
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= read_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_code_reg <= CC_RESET;
      cpu_run <= 1'b1;
      periph_run <= 1'b1;
      osc_enable <= 1'b1;
    end else if (clk_en) begin
      condition_code_reg <= next_cc;
      cpu_run <= next_mode == MODE_RUN;
      periph_run <= (next_mode == MODE_RUN) | (next_mode == MODE_WAIT);
      osc_enable <= next_mode != MODE_HALT;
    end
  end

endmodule

`default_nettype wire

// ==== nipl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module nipl_asserts #(
  parameter int STAB_COUNT = 512
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // core side
  input wire logic cpu_op_valid,
  input wire nipl_pkg::nipl_op_type cpu_op,
  input wire logic [7:0] cpu_cc_in,
  input wire logic irq_ack,
  input wire logic irq_req,
  input wire logic [3:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  input wire logic [7:0] condition_code_reg,
  // power
  input wire logic cpu_run,
  input wire logic periph_run,
  input wire logic osc_enable
);
  import nipl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [1:0] prio = {condition_code_reg[5], condition_code_reg[3]};
  // op taken: run mode, clock on, not pre-empted by an ack
  wire go = cpu_op_valid && cpu_run && clk_en && !(irq_ack && irq_req);

  a_rim_level0: assert property (go && cpu_op == OP_RIM |=> prio == PRIO_LEVEL0)
    else $error("enable op did not give level 0");
  a_sim_level3: assert property (go && cpu_op inside {OP_SIM, OP_TRAP} |=>
    prio == PRIO_LEVEL3)
    else $error("disable or trap did not give level 3");
  a_pop_whole: assert property (go && cpu_op inside {OP_POPCC, OP_RETURN_FROM_IRQ_INSTR} |=>
    condition_code_reg == ($past(cpu_cc_in) | CC_FIXED_ONES))
    else $error("popped condition code not restored");
  a_wfi_cpu_only: assert property (go && cpu_op == OP_WFI |=>
    !cpu_run && periph_run && prio == PRIO_LEVEL0)
    else $error("wait entry wrong");
  a_halt_all_stop: assert property (go && cpu_op == OP_HALT |=>
    !cpu_run && !periph_run && !osc_enable && prio == PRIO_LEVEL0)
    else $error("halt entry wrong");
  a_nmi_level3: assert property (irq_ack && irq_req && irq_vector == 4'h0 && clk_en |=>
    prio == PRIO_LEVEL3)
    else $error("top level entry did not give level 3");
  a_vector_addr: assert property (irq_req |->
    irq_vector_addr == VEC_ADDR_TOP - {11'h0, irq_vector, 1'b0})
    else $error("vector address wrong");
  // cycles with the oscillator back but cpu and peripherals still held
  logic [15:0] stab_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_seen <= 16'h0000;
    end else if (clk_en) begin
      if (osc_enable && !cpu_run && !periph_run) begin
        stab_seen <= stab_seen + 16'h0001;
      end else begin
        stab_seen <= 16'h0000;
      end
    end
  end
  a_stab_wait: assert property ($rose(cpu_run) && !$past(periph_run) |->
    stab_seen == 16'(STAB_COUNT))
    else $error("stabilisation time wrong");
endmodule
bind nipl_controller nipl_asserts #(.STAB_COUNT(STAB_COUNT)) chk_u (.pclk, .presetn, .clk_en,
  .cpu_op_valid, .cpu_op, .cpu_cc_in, .irq_ack, .irq_req, .irq_vector, .irq_vector_addr,
  .condition_code_reg, .cpu_run, .periph_run, .osc_enable);
`default_nettype wire

// ==== nipl_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nipl_cpu_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and control
  input wire logic irq_req,
  input wire logic hold,
  input wire logic slow,
  // answer
  output logic irq_ack,
  output logic [7:0] n_acks
);
  logic [2:0] cnt;
  // acks only, never a priority-changing op from inside a routine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      cnt <= 3'h0;
      n_acks <= 8'h0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      cnt <= 3'h0;
      n_acks <= n_acks + 8'h1;
    end else if (irq_req && !hold) begin
      if (cnt >= (slow ? 3'h3 : 3'h0)) irq_ack <= 1'b1;
      else cnt <= cnt + 3'h1;
    end else begin
      cnt <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ==== test_nested_irq_priority_and_low_power.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s: expected %h, seen %h", n, e, s); end end
module test_nested_irq_priority_and_low_power;
  import nipl_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic er;}
    nipl_row_type;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic cpu_op_valid, irq_ack, irq_req, cpu_run, periph_run, osc_enable, hold, slow;
  logic [7:0] paddr, cpu_cc_in, condition_code_reg, n_acks;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] irq_vector;
  logic [15:0] irq_vector_addr;
  logic [13:0] irq_lines;
  nipl_op_type cpu_op;
  int err_count, n_checks, i;
  wire [1:0] prio = {condition_code_reg[5], condition_code_reg[3]};
  nipl_row_type rows [9] = '{
    '{0, OFF_CC, 8'h0, CC_RESET, 0},
    '{0, OFF_VECTOR_PRIORITY_3, 8'h0, ISPR_RESET, 0},
    '{1, OFF_VECTOR_PRIORITY_0, 8'h64, 8'h74, 0},
    '{1, OFF_VECTOR_PRIORITY_3, 8'h05, 8'hF5, 0},
    '{1, OFF_VECTOR_PRIORITY_3, 8'h0E, 8'hFD, 0},
    '{1, OFF_VECTOR_PRIORITY_2, 8'hAA, 8'hFF, 0},
    '{1, OFF_VECTOR_PRIORITY_1, 8'h00, 8'h00, 0},
    '{1, OFF_STATUS, 8'hFF, 8'h00, 0},
    '{1, 8'h1C, 8'h55, 8'h00, 1}};

  nipl_controller #(.STAB_COUNT(8)) dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_op_valid, .cpu_op, .cpu_cc_in, .irq_ack,
    .irq_req, .irq_vector, .irq_vector_addr, .condition_code_reg, .irq_lines, .cpu_run,
    .periph_run, .osc_enable);
  nipl_cpu_model cpu_u (.pclk, .presetn, .irq_req, .hold, .slow, .irq_ack, .n_acks);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task stop_test;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task op(input nipl_op_type o, input logic [7:0] c);
    @(posedge pclk);
    cpu_op <= o;
    cpu_cc_in <= c;
    cpu_op_valid <= 1'b1;
    @(posedge pclk);
    cpu_op_valid <= 1'b0;
    #1;
  endtask

  task pulse(input int v);
    @(posedge pclk);
    irq_lines[v] <= 1'b1;
    @(posedge pclk);
    irq_lines[v] <= 1'b0;
  endtask

  // bounded wait for the request line to reach a level
  task automatic wt(input logic lvl);
    int k;
    for (k = 0; k < 40 && irq_req !== lvl; k++) @(posedge pclk);
    #1;
  endtask

  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    stop_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, cpu_op_valid, hold, slow} = 7'h0;
    {paddr, pwdata, cpu_cc_in, irq_lines} = 62'h0;
    clk_en = 1'b1;
    cpu_op = OP_RIM;
    err_count = 0;
    n_checks = 0;
    rst;
    for (i = 0; i < 9; i++) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, {24'h0, rows[i].d});
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("read data", {24'h0, rows[i].e}, rd)
      `CHK("slave error", rows[i].er, er)
    end
    $display("register table done");
    op(OP_RIM, 8'h0);
    rst;
    `CHK("cc after reset", CC_RESET, condition_code_reg)
    `CHK("power after reset", 3'b111, {cpu_run, periph_run, osc_enable})
    op(OP_POPCC, 8'h15);
    `CHK("popped cc", 8'hD5, condition_code_reg)
    op(OP_SIM, 8'h0);
    `CHK("disable level", PRIO_LEVEL3, prio)
    op(OP_RIM, 8'h0);
    `CHK("enable level", PRIO_LEVEL0, prio)
    op(OP_TRAP, 8'h0);
    `CHK("trap level", PRIO_LEVEL3, prio)
    $display("reset and op test done");
    apb(1'b1, OFF_IRQ_EN, 32'h3FFE);
    apb(1'b1, OFF_VECTOR_PRIORITY_0, 32'h04);
    op(OP_RIM, 8'h0);
    hold = 1'b1;
    @(posedge pclk);
    irq_lines[3:1] <= 3'b111;
    @(posedge pclk);
    irq_lines <= 14'h0;
    wt(1'b1);
    `CHK("winner", 4'h2, irq_vector)
    `CHK("winner address", 16'hFFF6, irq_vector_addr)
    hold = 1'b0;
    wt(1'b0);
    `CHK("entry level", PRIO_LEVEL2, prio)
    repeat (3) @(posedge pclk);
    #1;
    `CHK("equal level held", 1'b0, irq_req)
    // pending again, then its field is raised above the running level
    pulse(2);
    apb(1'b1, OFF_VECTOR_PRIORITY_0, 32'h34);
    wt(1'b1);
    `CHK("re-entry", 4'h2, irq_vector)
    wt(1'b0);
    op(OP_RETURN_FROM_IRQ_INSTR, 8'hE2);
    wt(1'b1);
    `CHK("after return", 4'h3, irq_vector)
    wt(1'b0);
    $display("arbitration test done");
    op(OP_SIM, 8'h0);
    hold = 1'b1;
    pulse(0);
    wt(1'b1);
    `CHK("nmi at level 3", 4'h0, irq_vector)
    // drop to level 2 so the entry level is really loaded
    op(OP_POPCC, 8'hC0);
    hold = 1'b0;
    wt(1'b1);
    wt(1'b0);
    `CHK("nmi level", PRIO_LEVEL3, prio)
    $display("nmi test done");
    slow = 1'b1;
    op(OP_WFI, 8'h0);
    `CHK("wait power", 2'b01, {cpu_run, periph_run})
    pulse(5);
    wt(1'b1);
    `CHK("wait wake", 5'h15, {cpu_run, irq_vector})
    wt(1'b0);
    $display("wait test done");
    hold = 1'b1;
    op(OP_HALT, 8'h0);
    `CHK("halt osc", 1'b0, osc_enable)
    pulse(5);
    repeat (10) @(posedge pclk);
    #1;
    `CHK("no wake source", 2'b00, {osc_enable, cpu_run})
    pulse(3);
    wt(1'b1);
    `CHK("first after halt", 4'h3, irq_vector)
    hold = 1'b0;
    wt(1'b0);
    wt(1'b1);
    `CHK("second after halt", 4'h5, irq_vector)
    wt(1'b0);
    $display("halt test done");
    // a frozen clock enable must swallow the op
    @(posedge pclk);
    clk_en <= 1'b0;
    op(OP_RIM, 8'h0);
    `CHK("frozen level", PRIO_LEVEL3, prio)
    clk_en <= 1'b1;
    `CHK("acks taken", 8'h07, n_acks)
    $display("clock enable test done");
    stop_test;
  end
endmodule
`default_nettype wire
